// *** design/fpm_pkg.sv ***
package fpm_pkg;
  // ************************************************************
  // apb register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_GPI = 8'h00;
  localparam logic [7:0] OFS_LOCK = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0C;
  localparam logic [7:0] OFS_WDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RDATA = 8'h18;

  // ************************************************************
  // fields and widths
  // ************************************************************
  localparam int GPI_W = 5;
  localparam int SECTORS = 8;
  localparam int AW = 19;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int SECT_LSB = 16;
  localparam int TOP_SECTOR = 7;
  localparam int CMD_PROG_BIT = 0;
  localparam int CMD_ERASE_BIT = 1;
  localparam int SR_READY_BIT = 7;
  localparam int SR_ERASE_BIT = 5;
  localparam int SR_PROG_BIT = 4;
  localparam int SR_PROT_BIT = 1;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [1:0] STRAP_CYC = 2'h2;

  // ************************************************************
  // programming port commands
  // ************************************************************
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;

  typedef enum logic [1:0] {
    ST_ARRAY = 2'b00,
    ST_STATUS = 2'b01,
    ST_PROG = 2'b10,
    ST_ERASE = 2'b11
  } fpm_mode_e;
endpackage

// *** design/fpm_sync.sv ***
`timescale 1ns/100ps
module fpm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fpm_sync_s;

  fpm_sync_s r;
  fpm_sync_s next_r;

  // first stage feeds only the second
  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule

// *** design/fpm_protect.sv ***
`timescale 1ns/100ps
module fpm_protect (
  input wire logic [2:0] sector,
  input wire logic top_sector_lock_n,
  input wire logic write_protect_n,
  input wire logic [fpm_pkg::SECTORS-1:0] lock,
  output logic allowed
);
  logic hw_block;

  // pin level only gates, it never touches the lock bits
  always_comb begin
    if (sector == 3'(fpm_pkg::TOP_SECTOR)) begin
      hw_block = !top_sector_lock_n;
    end else begin
      hw_block = !write_protect_n;
    end
    allowed = !hw_block && !lock[sector];
  end
endmodule

// *** design/fpm_top.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - The five general inputs are synchronised and read back in the low bits of a register.
// - With the top lock pin low, program or erase of sector 7 is refused.
// - With the top lock pin high, sector 7 still obeys its lock bit; pins never alter locks.
// - With the write-protect pin low, program or erase of sectors 0 to 6 is refused.
// - With the write-protect pin high, sectors 0 to 6 still obey their lock bits.
// - In mux mode the row address bits are latched from the shared pins by the row strobe.
// - The row/column select tells whether the shared pins carry row or column bits.
// - In mux mode address and data are latched on the rising edge of the write strobe.
// - In mux mode the data pins take commands and data on writes and drive array or status on reads.
// - Data pins float whenever the device is in reset or the output gate is off.
// - In mux mode the data pins are driven only while the output gate enables them.
// - In mux mode the ready/busy pin follows bit 7 of the status byte.
// - Leaving reset the device is in array-read state.
module fpm_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [fpm_pkg::GPI_W-1:0] general_inputs,
  input wire logic top_sector_lock_n,
  input wire logic write_protect_n,
  input wire logic interface_select,
  input wire logic [fpm_pkg::ROW_W-1:0] mux_addr,
  input wire logic row_col_sel,
  input wire logic write_n,
  input wire logic out_gate_n,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe,
  output logic ready_busy_out,
  output logic [fpm_pkg::AW-1:0] arr_addr,
  input wire logic [7:0] arr_rdata,
  input wire logic arr_busy,
  output logic arr_prog,
  output logic arr_erase,
  output logic [fpm_pkg::AW-1:0] arr_op_addr,
  output logic [7:0] arr_wdata
);
  localparam int SW = fpm_pkg::GPI_W + fpm_pkg::ROW_W + 14; // six single pins and the data byte

  typedef struct packed {
    logic [1:0] strap_cnt;
    logic strap_done;
    logic mode_mux;
    logic [31:0] prdata;
    logic [fpm_pkg::AW-1:0] hub_addr;
    logic [7:0] hub_wdata;
    logic [fpm_pkg::SECTORS-1:0] lock;
    logic err_prog;
    logic err_erase;
    logic err_prot;
    logic [fpm_pkg::ROW_W-1:0] row;
    logic [fpm_pkg::COL_W-1:0] col;
    logic we_prev;
    fpm_pkg::fpm_mode_e mstate;
    logic [fpm_pkg::AW-1:0] op_addr;
    logic [7:0] op_wdata;
    logic op_prog;
    logic op_erase;
    logic [7:0] dq_out;
  } fpm_top_s;

  fpm_top_s r;
  fpm_top_s next_r;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;
  logic [fpm_pkg::GPI_W-1:0] gpi_s;
  logic tsl_s;
  logic wp_s;
  logic sel_s;
  logic [fpm_pkg::ROW_W-1:0] addr_s;
  logic rc_s;
  logic we_s;
  logic oe_s;
  logic [7:0] dq_s;

  assign pins_raw = {general_inputs, top_sector_lock_n, write_protect_n, interface_select,
                     mux_addr, row_col_sel, write_n, out_gate_n, dq_i};
  assign {gpi_s, tsl_s, wp_s, sel_s, addr_s, rc_s, we_s, oe_s, dq_s} = pins_s;

  fpm_sync #(.W(SW)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(pins_raw),
    .q(pins_s)
  );

  // ************************************************************
  // operation launch and protection
  // ************************************************************
  logic apb_wr;
  logic apb_setup_rd;
  logic busy;
  logic we_rise;
  logic hub_go;
  logic mux_go;
  logic go;
  logic go_prog;
  logic [fpm_pkg::AW-1:0] go_addr;
  logic [7:0] go_data;
  logic [2:0] go_sector;
  logic allowed;
  logic [7:0] sr_byte;
  logic mapped;

  fpm_protect u_protect (
    .sector(go_sector),
    .top_sector_lock_n(tsl_s),
    .write_protect_n(wp_s),
    .lock(r.lock),
    .allowed(allowed)
  );

  assign apb_wr = psel && penable && pwrite;
  assign apb_setup_rd = psel && !penable && !pwrite;
  assign busy = arr_busy || r.op_prog || r.op_erase;
  assign we_rise = !r.we_prev && we_s;
  assign hub_go = r.strap_done && !r.mode_mux && apb_wr && paddr == fpm_pkg::OFS_CMD
                  && (pwdata[fpm_pkg::CMD_PROG_BIT] || pwdata[fpm_pkg::CMD_ERASE_BIT]);
  assign mux_go = r.strap_done && r.mode_mux && we_rise
                  && (r.mstate == fpm_pkg::ST_PROG
                      || (r.mstate == fpm_pkg::ST_ERASE && dq_s == fpm_pkg::CMD_CONFIRM));
  // a launch while busy is dropped; software polls ready first
  assign go = (hub_go || mux_go) && !busy;
  assign go_prog = r.mode_mux ? (r.mstate == fpm_pkg::ST_PROG)
                              : pwdata[fpm_pkg::CMD_PROG_BIT];
  assign go_addr = r.mode_mux ? {addr_s[fpm_pkg::COL_W-1:0], r.row} : r.hub_addr;
  assign go_data = r.mode_mux ? dq_s : r.hub_wdata;
  assign go_sector = go_addr[fpm_pkg::AW-1:fpm_pkg::SECT_LSB];

  always_comb begin
    sr_byte = '0;
    sr_byte[fpm_pkg::SR_READY_BIT] = !busy;
    sr_byte[fpm_pkg::SR_ERASE_BIT] = r.err_erase;
    sr_byte[fpm_pkg::SR_PROG_BIT] = r.err_prog;
    sr_byte[fpm_pkg::SR_PROT_BIT] = r.err_prot;
  end

  always_comb begin
    unique case (paddr)
      fpm_pkg::OFS_GPI, fpm_pkg::OFS_LOCK, fpm_pkg::OFS_CMD, fpm_pkg::OFS_ADDR,
      fpm_pkg::OFS_WDATA, fpm_pkg::OFS_STATUS, fpm_pkg::OFS_RDATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_r = r;
    next_r.op_prog = 1'b0;
    next_r.op_erase = 1'b0;
    next_r.we_prev = we_s;

    // strap taken once, after the synchroniser has filled
    if (!r.strap_done) begin
      next_r.strap_cnt = r.strap_cnt + 2'h1;
      if (r.strap_cnt == fpm_pkg::STRAP_CYC) begin
        next_r.mode_mux = sel_s;
        next_r.strap_done = 1'b1;
      end
    end

    // apb read data is built in the setup cycle
    if (apb_setup_rd) begin
      next_r.prdata = '0;
      unique case (paddr)
        fpm_pkg::OFS_GPI: next_r.prdata[fpm_pkg::GPI_W-1:0] = gpi_s;
        fpm_pkg::OFS_LOCK: next_r.prdata[fpm_pkg::SECTORS-1:0] = r.lock;
        fpm_pkg::OFS_ADDR: next_r.prdata[fpm_pkg::AW-1:0] = r.hub_addr;
        fpm_pkg::OFS_WDATA: next_r.prdata[7:0] = r.hub_wdata;
        fpm_pkg::OFS_STATUS: next_r.prdata[7:0] = sr_byte;
        fpm_pkg::OFS_RDATA: next_r.prdata[7:0] = arr_rdata;
        default: next_r.prdata = '0;
      endcase
    end

    if (apb_wr) begin
      unique case (paddr)
        fpm_pkg::OFS_LOCK: next_r.lock = pwdata[fpm_pkg::SECTORS-1:0];
        fpm_pkg::OFS_ADDR: next_r.hub_addr = pwdata[fpm_pkg::AW-1:0];
        fpm_pkg::OFS_WDATA: next_r.hub_wdata = pwdata[7:0];
        fpm_pkg::OFS_STATUS: begin
          if (pwdata[fpm_pkg::SR_ERASE_BIT]) begin
            next_r.err_erase = 1'b0;
          end
          if (pwdata[fpm_pkg::SR_PROG_BIT]) begin
            next_r.err_prog = 1'b0;
          end
          if (pwdata[fpm_pkg::SR_PROT_BIT]) begin
            next_r.err_prot = 1'b0;
          end
        end
        default: next_r.lock = r.lock;
      endcase
    end

    // row bits follow the pins while the strobe selects row, column while it selects column
    if (!rc_s) begin
      next_r.row = addr_s;
    end else begin
      next_r.col = addr_s[fpm_pkg::COL_W-1:0];
    end

    // programming port command decoder
    if (r.strap_done && r.mode_mux && we_rise) begin
      unique case (r.mstate)
        fpm_pkg::ST_PROG: next_r.mstate = fpm_pkg::ST_STATUS;
        fpm_pkg::ST_ERASE: begin
          next_r.mstate = (dq_s == fpm_pkg::CMD_CONFIRM) ? fpm_pkg::ST_STATUS
                                                        : fpm_pkg::ST_ARRAY;
        end
        fpm_pkg::ST_ARRAY, fpm_pkg::ST_STATUS: begin
          unique case (dq_s)
            fpm_pkg::CMD_PROGRAM, fpm_pkg::CMD_PROGRAM_ALT: next_r.mstate = fpm_pkg::ST_PROG;
            fpm_pkg::CMD_ERASE: next_r.mstate = fpm_pkg::ST_ERASE;
            fpm_pkg::CMD_READ_STATUS: next_r.mstate = fpm_pkg::ST_STATUS;
            fpm_pkg::CMD_CLR_STATUS: begin
              next_r.err_erase = 1'b0;
              next_r.err_prog = 1'b0;
              next_r.err_prot = 1'b0;
            end
            fpm_pkg::CMD_READ_ARRAY: next_r.mstate = fpm_pkg::ST_ARRAY;
            default: next_r.mstate = r.mstate;
          endcase
        end
      endcase
    end

    // launch or refusal; error sets come last so they win over a clear
    if (go) begin
      if (allowed) begin
        next_r.op_prog = go_prog;
        next_r.op_erase = !go_prog;
        next_r.op_addr = go_addr;
        next_r.op_wdata = go_data;
      end else begin
        next_r.err_prot = 1'b1;
        if (go_prog) begin
          next_r.err_prog = 1'b1;
        end else begin
          next_r.err_erase = 1'b1;
        end
      end
    end

    next_r.dq_out = (r.mstate == fpm_pkg::ST_ARRAY) ? arr_rdata : sr_byte;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.lock <= fpm_pkg::LOCK_RST;
      r.we_prev <= 1'b1;
      r.mstate <= fpm_pkg::ST_ARRAY;
    end else begin
      r <= next_r;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = r.prdata;
  // reset clears mode_mux, so the pins float during and right after reset
  assign dq_oe = r.mode_mux && !oe_s && we_s;
  assign dq_o = r.dq_out;
  assign ready_busy_out = r.mode_mux && sr_byte[fpm_pkg::SR_READY_BIT];
  assign arr_addr = r.mode_mux ? {r.col, r.row} : r.hub_addr;
  assign arr_prog = r.op_prog;
  assign arr_erase = r.op_erase;
  assign arr_op_addr = r.op_addr;
  assign arr_wdata = r.op_wdata;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_we_rise_in_prog;
    we_rise && r.mode_mux && r.strap_done && r.mstate == fpm_pkg::ST_PROG && !busy;
  endsequence

  sequence s_prog_issued(logic [7:0] d);
    arr_prog && arr_wdata == d;
  endsequence

  a_gpi_readback: assert property (apb_setup_rd && paddr == fpm_pkg::OFS_GPI
    |=> prdata[fpm_pkg::GPI_W-1:0] == $past(gpi_s) && prdata[31:fpm_pkg::GPI_W] == '0)
    else $error("general input readback wrong");
  a_top_pin_guard: assert property (go && !tsl_s && go_sector == 3'(fpm_pkg::TOP_SECTOR)
    |=> !arr_prog && !arr_erase && r.err_prot)
    else $error("top sector written while pin locked");
  a_top_lock_reg: assert property (go && tsl_s && go_sector == 3'(fpm_pkg::TOP_SECTOR)
    && r.lock[fpm_pkg::TOP_SECTOR] |=> !arr_prog && !arr_erase)
    else $error("top sector lock bit ignored");
  a_low_pin_guard: assert property (go && !wp_s && go_sector != 3'(fpm_pkg::TOP_SECTOR)
    |=> !arr_prog && !arr_erase && r.err_prot)
    else $error("lower sector written while protected");
  a_low_lock_reg: assert property (go && wp_s && r.lock[go_sector]
    |=> !arr_prog && !arr_erase)
    else $error("lower sector lock bit ignored");
  a_row_latch: assert property (!rc_s [*2] |-> r.row == $past(addr_s))
    else $error("row address not latched");
  a_we_latch: assert property (s_we_rise_in_prog and allowed
    |=> s_prog_issued($past(dq_s)) ##1 !arr_prog)
    else $error("write data not latched on strobe edge");
  a_dq_float: assert property (oe_s || !r.mode_mux |-> !dq_oe)
    else $error("data pins driven while disabled");
  a_dq_drive: assert property ($fell(oe_s) && we_s && r.mode_mux |-> dq_oe)
    else $error("data pins not driven with output gate on");
  a_rdy_mirror: assert property (r.mode_mux && (r.op_prog || r.op_erase)
    |-> !ready_busy_out)
    else $error("ready pin high while busy");
  a_ok_launch: assert property (go && allowed |=> arr_prog || arr_erase)
    else $error("allowed operation not started");
  a_array_state: assert property ($rose(r.strap_done) |-> r.mstate == fpm_pkg::ST_ARRAY)
    else $error("not in array read after reset");
  a_col_latch: assert property (rc_s
    |=> r.row == $past(r.row) && r.col == $past(addr_s[fpm_pkg::COL_W-1:0]))
    else $error("column phase disturbed row or missed column");
  a_dq_source: assert property (r.mode_mux
    |=> dq_o == $past(r.mstate == fpm_pkg::ST_ARRAY ? arr_rdata : sr_byte))
    else $error("data pins carry wrong source");
endmodule

// *** verif/fpm_array_model.sv ***
`timescale 1ns/100ps
// ************************************************************
// array stand-in: random busy time, contents kept over reset
// ************************************************************
module fpm_array_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [fpm_pkg::AW-1:0] arr_addr,
  input wire logic arr_prog,
  input wire logic arr_erase,
  input wire logic [fpm_pkg::AW-1:0] arr_op_addr,
  input wire logic [7:0] arr_wdata,
  output logic [7:0] arr_rdata,
  output logic arr_busy
);
  logic [7:0] mem [logic [fpm_pkg::AW-1:0]];
  int ver = 0;
  int cnt = 0;
  // ver forces a re-read when the byte under arr_addr changes
  always @(arr_addr or ver) arr_rdata = mem.exists(arr_addr) ? mem[arr_addr] : 8'hFF;
  assign arr_busy = (cnt != 0);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
    end else if (arr_prog || arr_erase) begin
      // 0 to 6 busy cycles: both prompt and slow array
      cnt <= $urandom % 7;
      if (arr_prog) begin
        // programming only clears bits, as real cells do
        mem[arr_op_addr] = (mem.exists(arr_op_addr) ? mem[arr_op_addr] : 8'hFF) & arr_wdata;
      end else begin
        foreach (mem[k]) if (k[18:16] == arr_op_addr[18:16]) mem[k] = 8'hFF;
      end
      ver = ver + 1;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [4:0] general_inputs = 0;
  logic top_sector_lock_n = 1, write_protect_n = 1, interface_select = 0;
  logic [10:0] mux_addr = 0;
  logic row_col_sel = 0, write_n = 1, out_gate_n = 1, dq_oe, ready_busy_out;
  logic [7:0] dq_i = 0, dq_o, arr_rdata, arr_wdata, d, lk;
  logic [18:0] arr_addr, arr_op_addr, a;
  logic arr_busy, arr_prog, arr_erase, err, wp, tb, op, al, seen_busy;
  logic [7:0] em [logic [18:0]];
  int error_cnt = 0, checks = 0, cyc = 0;

  fpm_top dut_u (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .general_inputs, .top_sector_lock_n, .write_protect_n, .interface_select,
    .mux_addr, .row_col_sel, .write_n, .out_gate_n, .dq_i, .dq_o, .dq_oe, .ready_busy_out,
    .arr_addr, .arr_rdata, .arr_busy, .arr_prog, .arr_erase, .arr_op_addr, .arr_wdata);
  fpm_array_model arr_u (.clk, .rstn, .arr_addr, .arr_prog, .arr_erase, .arr_op_addr,
    .arr_wdata, .arr_rdata, .arr_busy);

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] er(input logic [18:0] ad);
    return em.exists(ad) ? em[ad] : 8'hFF;
  endfunction
  task automatic upd(input logic ers, input logic [18:0] ad, input logic [7:0] dv);
    if (ers) foreach (em[k]) begin
      if (k[18:16] == ad[18:16]) em[k] = 8'hFF;
    end
    else em[ad] = er(ad) & dv;
  endtask
  task automatic do_reset(input logic sel);
    @(posedge clk);
    rstn <= 0;
    interface_select <= sel;
    repeat (6) @(posedge clk);
    rstn <= 1;
    repeat (6) @(posedge clk);
  endtask
  // one transfer; waits on pready, only the watchdog ends a hung wait
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic hub_wait;
    do begin
      apb(0, fpm_pkg::OFS_STATUS, 0);
    end while (rd[7] !== 1'b1);
  endtask
  // pins are synchronised, so every phase is held four cycles
  task automatic mux_wr(input logic [18:0] ad, input logic [7:0] dv);
    @(posedge clk);
    row_col_sel <= 0;
    mux_addr <= ad[10:0];
    repeat (4) @(posedge clk);
    row_col_sel <= 1;
    mux_addr <= {3'h0, ad[18:11]};
    write_n <= 0;
    dq_i <= dv;
    repeat (4) @(posedge clk);
    write_n <= 1;
    repeat (4) @(posedge clk);
    dq_i <= ~dv;
  endtask
  task automatic mux_rd(input logic [18:0] ad);
    mux_wr(19'h0, fpm_pkg::CMD_READ_ARRAY);
    row_col_sel <= 0;
    mux_addr <= ad[10:0];
    repeat (4) @(posedge clk);
    row_col_sel <= 1;
    mux_addr <= {3'h0, ad[18:11]};
    out_gate_n <= 0;
    repeat (6) @(posedge clk);
    check("mux data", dq_o, er(ad));
    check("mux drive", dq_oe, 1);
    out_gate_n <= 1;
    repeat (4) @(posedge clk);
    check("mux float", dq_oe, 0);
  endtask
  task automatic mux_op(input logic [7:0] cmd, input logic [18:0] ad, input logic [7:0] dv);
    mux_wr(ad, cmd);
    mux_wr(ad, dv);
    // the launch of the edge just passed still shows here, even with a prompt array
    seen_busy = (ready_busy_out === 1'b0);
    while (ready_busy_out !== 1'b1) begin
      @(posedge clk);
      if (ready_busy_out === 1'b0) seen_busy = 1;
    end
    if (al) check("busy seen", seen_busy, 1);
    out_gate_n <= 0;
    repeat (4) @(posedge clk);
    check("status ready", dq_o[7], 1);
    check("ready pin", ready_busy_out, 1);
    check("status prot", dq_o[1], !al);
    out_gate_n <= 1;
    mux_wr(19'h0, fpm_pkg::CMD_CLR_STATUS);
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    void'($urandom(48269));
    do_reset(0);
    apb(0, fpm_pkg::OFS_LOCK, 0);
    check("lock reset", rd, 32'h000000FF);
    apb(0, 8'h40, 0);
    check("unmapped err", err, 1);
    check("unmapped data", rd, 0);
    $display("test reset and map done");
    for (int t = 0; t < 16; t++) begin
      s_pick(t);
    end
    $display("test hub protection done");
    do_reset(0);
    apb(0, fpm_pkg::OFS_LOCK, 0);
    check("lock after reset", rd, 32'h000000FF);
    apb(1, fpm_pkg::OFS_ADDR, {13'h0, a});
    apb(0, fpm_pkg::OFS_RDATA, 0);
    check("array after reset", rd[7:0], er(a));
    $display("test mid-run reset done");
    do_reset(1);
    apb(1, fpm_pkg::OFS_LOCK, 0);
    for (int t = 0; t < 4; t++) begin
      wp = (t != 1);
      al = wp;
      write_protect_n <= wp;
      a = {3'($urandom % 7), 16'($urandom)};
      d = $urandom;
      mux_op(t[0] ? fpm_pkg::CMD_PROGRAM_ALT : fpm_pkg::CMD_PROGRAM, a, d);
      if (al) upd(0, a, d);
      mux_rd(a);
    end
    mux_wr(19'h0, fpm_pkg::CMD_READ_STATUS);
    out_gate_n <= 0;
    repeat (4) @(posedge clk);
    check("read status", dq_o, 8'h80);
    out_gate_n <= 1;
    mux_op(fpm_pkg::CMD_ERASE, a, fpm_pkg::CMD_CONFIRM);
    upd(1, a, 0);
    mux_rd(a);
    $display("test mux port done");
    tally_and_finish();
  end

  // ************************************************************
  // one hub launch against the pin setting picked by t and a random lock setting
  // ************************************************************
  task automatic s_pick(input int t);
    logic [2:0] s;
    s = t[0] ? 3'h7 : 3'($urandom % 7);
    a = {s, 16'($urandom)};
    d = $urandom;
    lk = $urandom;
    if (!t[3]) lk[s] = 0;
    wp = t[1];
    tb = t[2];
    op = t[3];
    al = !lk[s] && (s == 3'h7 ? tb : wp);
    write_protect_n <= wp;
    top_sector_lock_n <= tb;
    general_inputs <= $urandom;
    apb(1, fpm_pkg::OFS_LOCK, {24'h0, lk});
    apb(1, fpm_pkg::OFS_ADDR, {13'h0, a});
    apb(1, fpm_pkg::OFS_WDATA, {24'h0, d});
    apb(0, fpm_pkg::OFS_GPI, 0);
    check("gpi", rd, {27'h0, general_inputs});
    apb(1, fpm_pkg::OFS_CMD, op ? 32'h2 : 32'h1);
    hub_wait();
    check("prot flag", rd[1], !al);
    check("fail flag", op ? rd[5] : rd[4], !al);
    if (al) upd(op, a, d);
    apb(1, fpm_pkg::OFS_STATUS, 32'h32);
    apb(0, fpm_pkg::OFS_RDATA, 0);
    check("array", rd[7:0], er(a));
    apb(0, fpm_pkg::OFS_LOCK, 0);
    check("lock kept", rd, {24'h0, lk});
    check("hub ready pin", ready_busy_out, 0);
  endtask
endmodule
